/* rtl/dind_top.sv */
// eight channel digital input with filters and diagnostic records
//
// Notes on behaviour
// RULE1 - wire-break watch per channel enable bit
// RULE2 - filter byte: low nibble even, high odd
// RULE3 - filter codes 1..7 map 100us to 20ms
// RULE4 - inputs delayed by filter time, spikes dropped
// RULE5 - wire breaks reported only for enabled channels
// RULE6 - record 01h full diag, 00h first four
// RULE7 - index 2F01h full diag, 2F00h first four
// RULE8 - subindex path under 5005h, 02h to 13h; the block answers 02h to 11h and 13h, and 12h reads bad
// RULE9 - first diag byte summary error bits
// RULE10 - fourth byte: overflow bit3, comm bit4
// RULE11 - module class byte reads 1Fh
// RULE12 - channel kind byte reads 70h
// RULE13 - bits per channel and count read 08h
// RULE14 - summary bit n set on channel error
// RULE15 - channel byte: param bit0, wire bit4
// RULE16 - timestamp captured on diagnostic event
// RULE17 - 32-bit microsecond counter from zero, wraps
// RULE18 - diag enable 00h off, 40h on
// RULE19 - controller writes enables only when stopped
// RULE20 - channel flag sets summary bits, reset clear
// RULE21 - bad filter code flags parameter error
`include "dind_regs.svh"

module dind_top
    import dind_pkg::*;
#(
    parameter logic [7:0] US_CYCLES = 8'(`DIND_US_CYCLES)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // process side
    input wire logic [7:0] input_channel,
    input wire logic [7:0] wire_break_sense,
    input wire logic module_fail,
    input wire logic aux_supply_missing,
    input wire logic diag_overflow,
    input wire logic comm_error,
    // coupler access
    input wire dind_req_t req,
    output dind_rsp_t rsp,
    // results
    output logic [7:0] input_state,
    output logic diag_alarm
);

    logic [1:0] rst_sync;
    logic rst_n;
    dind_state_t st_reg;
    dind_state_t st_next;
    logic [19:0][7:0] diag;
    logic [7:0][7:0] che;
    logic [7:0] perr;
    logic [7:0] wb;
    logic [7:0] chsum;
    logic [7:0] sum;
    logic [7:0] intl;
    logic en;
    logic [23:0] ev_vec;
    logic [2:0] ps;
    logic [5:0] dsel;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // filter code to delay in microseconds
    function automatic logic [14:0] filt_us(logic [3:0] code);
        logic [14:0] t;
        t = `DIND_FILT_T1_US;
        unique case (code)
            4'h1: t = `DIND_FILT_T1_US; // RULE3
            4'h2: t = `DIND_FILT_T2_US;
            4'h3: t = `DIND_FILT_T3_US;
            4'h4: t = `DIND_FILT_T4_US;
            4'h5: t = `DIND_FILT_T5_US;
            4'h6: t = `DIND_FILT_T6_US;
            4'h7: t = `DIND_FILT_T7_US;
            default: t = `DIND_FILT_T1_US;
        endcase
        return t;
    endfunction

    // parameter slot: 0 none, 1 diag enable, 2 wire enable, 3..6 filter
    function automatic logic [2:0] param_slot(dind_req_t r);
        logic [2:0] s;
        s = 3'h0;
        unique case (r.path)
            DIND_PATH_RECORD: begin
                if (r.number == `DIND_REC_PARAM && r.offset < 5'h02) begin
                    s = 3'h1 + 3'(r.offset);
                end else if (r.number[15:2] == `DIND_REC_FILT0 >> 2
                        && r.offset == 5'h00) begin
                    s = 3'h3 + 3'(r.number[1:0]);
                end
            end
            DIND_PATH_INDEX: begin
                if (r.number >= `DIND_IDX_PARAM0
                        && r.number <= `DIND_IDX_PARAM0 + 16'h0005
                        && r.offset == 5'h00) begin
                    s = 3'(r.number - `DIND_IDX_PARAM0) + 3'h1;
                end
            end
            DIND_PATH_SUBINDEX: begin
                if (r.number == `DIND_IDX_SUB_PARAM
                        && r.subindex >= `DIND_SUB_PARAM_FIRST
                        && r.subindex <= `DIND_SUB_PARAM_LAST
                        && r.offset == 5'h00) begin
                    s = 3'(r.subindex);
                end
            end
            default: s = 3'h0;
        endcase
        return s;
    endfunction

    // diagnostic byte: bit 5 valid, bits 4..0 byte within the record
    function automatic logic [5:0] diag_slot(dind_req_t r);
        logic [5:0] s;
        s = 6'h00;
        unique case (r.path)
            DIND_PATH_RECORD: begin
                if (r.number == `DIND_REC_DIAG_FULL
                        && r.offset < `DIND_DIAG_LEN) begin
                    s = {1'b1, r.offset}; // RULE6
                end else if (r.number == `DIND_REC_DIAG_HEAD
                        && r.offset < `DIND_DIAG_HEAD_LEN) begin
                    s = {1'b1, r.offset}; // RULE6
                end
            end
            DIND_PATH_INDEX: begin
                if (r.number == `DIND_IDX_DIAG_FULL
                        && r.offset < `DIND_DIAG_LEN) begin
                    s = {1'b1, r.offset}; // RULE7
                end else if (r.number == `DIND_IDX_DIAG_HEAD
                        && r.offset < `DIND_DIAG_HEAD_LEN) begin
                    s = {1'b1, r.offset}; // RULE7
                end
            end
            DIND_PATH_SUBINDEX: begin
                if (r.number == `DIND_IDX_SUB_DIAG) begin
                    if (r.subindex >= `DIND_SUB_DIAG_FIRST
                            && r.subindex <= `DIND_SUB_DIAG_LAST
                            && r.offset == 5'h00) begin
                        s = {1'b1, 5'(r.subindex - `DIND_SUB_DIAG_FIRST)};
                    end else if (r.subindex == `DIND_SUB_STAMP
                            && r.offset < 5'h04) begin
                        s = {1'b1, `DIND_STAMP_BYTE + r.offset}; // RULE8
                    end
                end
            end
            default: s = 6'h00;
        endcase
        return s;
    endfunction

    // per-channel filters and error bytes
    assign en = (st_reg.report_en == `DIND_RPT_EN_ON); // RULE18
    assign wb = wire_break_sense & st_reg.wbe; // RULE1 RULE5
    generate
        for (genvar n = 0; n < 8; n++) begin : g_ch
            logic [3:0] code;
            assign code = st_reg.filt[n / 2][4 * (n % 2) +: 4]; // RULE2
            assign perr[n] = (code == 4'h0) || code[3]; // RULE21
            always_comb begin
                che[n] = 8'h00;
                che[n][`DIND_CHE_PARAM] = en && perr[n]; // RULE15
                che[n][`DIND_CHE_WIRE] = en && wb[n]; // RULE15 RULE5
            end
            assign chsum[n] = |che[n]; // RULE14 RULE20
            dind_filter u_filt (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .us_tick(st_reg.us_tick),
                .limit_us(filt_us(code)),
                .raw(input_channel[n]),
                .state(input_state[n])
            );
        end
    endgenerate

    // summary and internal bytes
    always_comb begin
        sum = 8'h00;
        intl = 8'h00;
        if (en) begin
            intl[`DIND_INT_OVF] = diag_overflow; // RULE10
            intl[`DIND_INT_COMM] = comm_error; // RULE10
            sum[`DIND_SUM_MOD_FAIL] = module_fail; // RULE9
            sum[`DIND_SUM_INTERNAL] = |intl;
            sum[`DIND_SUM_EXTERNAL] = aux_supply_missing;
            sum[`DIND_SUM_CHANNEL] = |chsum; // RULE20
            sum[`DIND_SUM_AUX] = aux_supply_missing;
            sum[`DIND_SUM_PARAM] = (|perr) // RULE21
                || (st_reg.report_en != `DIND_RPT_EN_OFF
                && st_reg.report_en != `DIND_RPT_EN_ON);
        end
    end

    // record image, timestamp low byte first
    always_comb begin
        diag = '0;
        diag[0] = sum; // RULE9
        diag[1] = `DIND_MOD_CLASS; // RULE11
        diag[3] = intl; // RULE10
        diag[4] = `DIND_CH_KIND; // RULE12
        diag[5] = `DIND_BITS_PER_CH; // RULE13
        diag[6] = `DIND_CH_COUNT; // RULE13
        diag[7] = chsum; // RULE14
        for (int i = 0; i < 8; i++) begin
            diag[`DIND_CHAN_ERR_BYTE + 5'(i)] = che[i];
        end
        for (int i = 0; i < 4; i++) begin
            diag[`DIND_STAMP_BYTE + 5'(i)] = st_reg.stamp[8 * i +: 8];
        end
    end

    assign ev_vec = {sum, chsum, wb & {8{en}}};
    assign ps = param_slot(req);
    assign dsel = diag_slot(req);

    // next state: ticker, event capture, access handling
    always_comb begin
        st_next = st_reg;
        st_next.rsp = '0;
        if (st_reg.us_pre == US_CYCLES - 8'h01) begin
            st_next.us_pre = 8'h00;
            st_next.us_tick = 1'b1;
            st_next.us_cnt = st_reg.us_cnt + 32'h00000001; // RULE17
        end else begin
            st_next.us_pre = st_reg.us_pre + 8'h01;
            st_next.us_tick = 1'b0;
        end
        st_next.ev_prev = ev_vec;
        st_next.alarm = |(ev_vec & ~st_reg.ev_prev);
        if (st_next.alarm) begin
            st_next.stamp = st_reg.us_cnt; // RULE16
        end
        if (req.valid) begin
            st_next.rsp.valid = 1'b1;
            if (req.write) begin
                unique case (ps)
                    3'h0: st_next.rsp.bad = 1'b1;
                    3'h1: st_next.report_en = req.wdata; // RULE18
                    3'h2: st_next.wbe = req.wdata; // RULE1
                    default: st_next.filt[2'(ps - 3'h3)] = req.wdata;
                endcase
            end else if (dsel[5]) begin
                st_next.rsp.data = diag[dsel[4:0]];
            end else begin
                unique case (ps)
                    3'h0: st_next.rsp.bad = 1'b1;
                    3'h1: st_next.rsp.data = st_reg.report_en;
                    3'h2: st_next.rsp.data = st_reg.wbe;
                    default: st_next.rsp.data = st_reg.filt[2'(ps - 3'h3)];
                endcase
            end
        end
    end

    // state register, flags clear at reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0; // RULE20
            st_reg.report_en <= `DIND_RPT_EN_RST;
            st_reg.wbe <= `DIND_WBE_RST;
            st_reg.filt <= {4{`DIND_FILT_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rsp = st_reg.rsp;
    assign diag_alarm = st_reg.alarm;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_wire_masked: assert property (req.valid && !req.write // RULE5
        && diag_slot(req) == 6'h28 && !st_reg.wbe[0] |=> !rsp.data[4])
        else $error("wire break shown for disabled channel");
    a_filt_nibble: assert property (req.valid && req.write // RULE2
        && param_slot(req) == 3'h3 |=> st_reg.filt[0] == $past(req.wdata))
        else $error("filter byte not stored");
    a_class_byte: assert property (req.valid && !req.write // RULE11
        && diag_slot(req) == 6'h21 |=> rsp.data == 8'h1f && !rsp.bad)
        else $error("module class byte wrong");
    a_head_limit: assert property (req.valid && !req.write // RULE6
        && req.path == DIND_PATH_RECORD && req.number == 16'h0000
        && req.offset == 5'h04 |=> rsp.valid && rsp.bad)
        else $error("short record not limited to four bytes");
    a_index_full: assert property (req.valid && !req.write // RULE7
        && req.path == DIND_PATH_INDEX && req.number == 16'h2f01
        && req.offset == 5'h06 |=> rsp.data == 8'h08 && !rsp.bad)
        else $error("full record by index misread");
    a_us_count: assert property (st_reg.us_tick // RULE17
        |-> st_reg.us_cnt == $past(st_reg.us_cnt) + 32'h00000001)
        else $error("microsecond counter did not advance");
    a_tick_space: assert property ($rose(st_reg.us_tick) // RULE17
        |=> !st_reg.us_tick)
        else $error("microsecond tick longer than a cycle");
    a_stamp_take: assert property (diag_alarm // RULE16
        |-> st_reg.stamp == $past(st_reg.us_cnt))
        else $error("timestamp not captured at event");
    a_perr_sum: assert property (en && st_reg.filt[1][7:4] == 4'h0 // RULE21
        |-> sum[7] && che[3][0] && chsum[3] && sum[3])
        else $error("bad filter code not flagged");
    a_diag_off: assert property (st_reg.report_en == 8'h00 // RULE18
        |-> sum == 8'h00 && chsum == 8'h00)
        else $error("reporting active while disabled");
    c_alarm: cover property (diag_alarm);
    c_wire_err: cover property (en && chsum[0]);
    c_write_rec: cover property (req.valid && req.write && ps == 3'h2);

endmodule

/* rtl/dind_regs.svh */
// offsets, field positions, reset values and timing of the input block
`ifndef DIND_REGS_SVH
`define DIND_REGS_SVH

`define DIND_CLK_HZ 200000000
`define DIND_US_CYCLES (`DIND_CLK_HZ / 1000000)

`define DIND_REC_PARAM 16'h0000
`define DIND_REC_DIAG_HEAD 16'h0000
`define DIND_REC_DIAG_FULL 16'h0001
`define DIND_REC_FILT0 16'h0080
`define DIND_IDX_DIAG_HEAD 16'h2f00
`define DIND_IDX_DIAG_FULL 16'h2f01
`define DIND_IDX_PARAM0 16'h3100
`define DIND_IDX_SUB_PARAM 16'h3100
`define DIND_IDX_SUB_DIAG 16'h5005
`define DIND_SUB_PARAM_FIRST 8'h01
`define DIND_SUB_PARAM_LAST 8'h06
`define DIND_SUB_DIAG_FIRST 8'h02
`define DIND_SUB_DIAG_LAST 8'h11
`define DIND_SUB_STAMP 8'h13

`define DIND_DIAG_HEAD_LEN 5'd4
`define DIND_DIAG_LEN 5'd20
`define DIND_CHAN_ERR_BYTE 5'd8
`define DIND_STAMP_BYTE 5'd16

`define DIND_RPT_EN_RST 8'h00
`define DIND_RPT_EN_OFF 8'h00
`define DIND_RPT_EN_ON 8'h40
`define DIND_WBE_RST 8'h00
`define DIND_FILT_RST 8'h11
`define DIND_MOD_CLASS 8'h1f
`define DIND_CH_KIND 8'h70
`define DIND_BITS_PER_CH 8'h08
`define DIND_CH_COUNT 8'h08

`define DIND_SUM_MOD_FAIL 0
`define DIND_SUM_INTERNAL 1
`define DIND_SUM_EXTERNAL 2
`define DIND_SUM_CHANNEL 3
`define DIND_SUM_AUX 4
`define DIND_SUM_PARAM 7
`define DIND_INT_OVF 3
`define DIND_INT_COMM 4
`define DIND_CHE_PARAM 0
`define DIND_CHE_WIRE 4

`define DIND_FILT_T1_US 15'd100
`define DIND_FILT_T2_US 15'd400
`define DIND_FILT_T3_US 15'd800
`define DIND_FILT_T4_US 15'd1600
`define DIND_FILT_T5_US 15'd3200
`define DIND_FILT_T6_US 15'd10000
`define DIND_FILT_T7_US 15'd20000

`endif

/* rtl/dind_pkg.sv */
// types shared by the input diagnostics block
package dind_pkg;

    typedef enum logic [1:0] {
        DIND_PATH_RECORD,
        DIND_PATH_INDEX,
        DIND_PATH_SUBINDEX
    } dind_path_t;

    typedef struct packed {
        logic valid;
        logic write;
        dind_path_t path;
        logic [15:0] number;
        logic [7:0] subindex;
        logic [4:0] offset;
        logic [7:0] wdata;
    } dind_req_t;

    typedef struct packed {
        logic valid;
        logic bad;
        logic [7:0] data;
    } dind_rsp_t;

    typedef struct packed {
        logic state;
        logic [14:0] cnt;
    } dind_filt_state_t;

    typedef struct packed {
        logic [7:0] report_en;
        logic [7:0] wbe;
        logic [3:0][7:0] filt;
        logic [7:0] us_pre;
        logic us_tick;
        logic [31:0] us_cnt;
        logic [31:0] stamp;
        logic [23:0] ev_prev;
        logic alarm;
        dind_rsp_t rsp;
    } dind_state_t;

endpackage

/* rtl/dind_filter.sv */
// one channel input delay filter counted in microsecond ticks
`include "dind_regs.svh"

module dind_filter
    import dind_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // timing
    input wire logic us_tick,
    input wire logic [14:0] limit_us,
    // signal
    input wire logic raw,
    output logic state
);

    dind_filt_state_t st_reg;
    dind_filt_state_t st_next;

    // output follows raw only after it differed for limit_us ticks
    always_comb begin
        st_next = st_reg;
        if (raw == st_reg.state) begin
            st_next.cnt = 15'h0000; // RULE4
        end else if (us_tick) begin
            if (st_reg.cnt + 15'h0001 >= limit_us) begin
                st_next.state = raw; // RULE4
                st_next.cnt = 15'h0000;
            end else begin
                st_next.cnt = st_reg.cnt + 15'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign state = st_reg.state;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_filt_change: assert property ($changed(st_reg.state) |-> // RULE4
        $past(us_tick) && $past(st_reg.cnt) + 15'h0001 >= $past(limit_us))
        else $error("filtered state changed before its delay");
    c_filt_flip: cover property ($rose(st_reg.state));

endmodule

/* verif/dind_coupler_model.sv */
// coupler model that issues register requests towards the block
module dind_coupler_model
    import dind_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // access port
    output dind_req_t req,
    input wire dind_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // one request per edge, block always answers next cycle
    task automatic access(input logic wr, input dind_path_t p,
        input logic [15:0] num, input logic [7:0] sub,
        input logic [4:0] off, input logic [7:0] wd);
        req <= '{1'b1, wr, p, num, sub, off, wd};
        @(posedge ref_clk);
    endtask

    // release: fields flip so stale values never look valid
    task automatic idle();
        req <= {1'b0, ~req[$bits(req)-2:0]};
    endtask
endmodule

/* verif/tb_top.sv */
// self-checking bench for the input diagnostics block
module tb_top
    import dind_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic bad;
        logic [7:0] lo;
        logic [7:0] hi;
    } dind_exp_t;

    localparam int US = 2;
    logic ref_clk, nrst, module_fail, aux_supply_missing;
    logic diag_overflow, comm_error, diag_alarm;
    logic [7:0] input_channel, wire_break_sense, input_state;
    dind_req_t req;
    dind_rsp_t rsp;
    dind_exp_t expq[$];
    dind_exp_t e;
    int mismatches = 0, n_compared = 0, n_alarm = 0, cyc = 0;
    int dly[8] = '{0, 100, 400, 800, 1600, 3200, 10000, 20000};
    logic [31:0] seed = 32'h82710a9f;
    logic [31:0] tk;
    logic on_m, mf_m, aux_m, ovf_m, comm_m, lvl;
    logic [7:0] wbe_m, sense_m;
    logic [3:0][7:0] filt_m;

    dind_top #(.US_CYCLES(8'(US))) dind_top_i (
        .ref_clk(ref_clk), .nrst(nrst), .input_channel(input_channel),
        .wire_break_sense(wire_break_sense), .module_fail(module_fail),
        .aux_supply_missing(aux_supply_missing),
        .diag_overflow(diag_overflow), .comm_error(comm_error),
        .req(req), .rsp(rsp), .input_state(input_state),
        .diag_alarm(diag_alarm));

    dind_coupler_model dind_coupler_model_i (
        .ref_clk(ref_clk), .req(req), .rsp(rsp));

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // cycle count since reset release, alarm count
    always @(posedge ref_clk) cyc <= nrst ? cyc + 1 : 0;
    always @(negedge ref_clk) if (diag_alarm === 1'b1) n_alarm++;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic fail(logic [7:0] exp, logic [7:0] got);
        mismatches++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    endtask

    task automatic chk(logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) fail(exp, got);
    endtask

    // filtered inputs are looked at mid-cycle, away from the edge
    task automatic chk_in(logic [7:0] exp);
        @(negedge ref_clk);
        chk(exp, input_state);
        @(posedge ref_clk);
    endtask

    // answer watcher: oldest note against each response
    always @(negedge ref_clk) begin
        if (rsp.valid === 1'b1) begin
            n_compared++;
            if (expq.size() == 0) fail(8'hee, rsp.data);
            else begin
                e = expq.pop_front();
                if (!(rsp.bad === e.bad && (rsp.data >= e.lo) === 1'b1
                    && (rsp.data <= e.hi) === 1'b1)) fail(e.lo, rsp.data);
            end
        end
    end

    task automatic gap(int n);
        dind_coupler_model_i.idle();
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic rd(dind_path_t p, logic [15:0] n, logic [7:0] s,
        logic [4:0] o, logic [7:0] lo, logic [7:0] hi);
        expq.push_back('{1'b0, lo, hi});
        dind_coupler_model_i.access(1'b0, p, n, s, o, 8'h00);
    endtask

    task automatic wr(dind_path_t p, logic [15:0] n, logic [7:0] s,
        logic [4:0] o, logic [7:0] d);
        expq.push_back('{1'b0, 8'h00, 8'hff});
        dind_coupler_model_i.access(1'b1, p, n, s, o, d);
    endtask

    task automatic bd(logic w, dind_path_t p, logic [15:0] n,
        logic [7:0] s, logic [4:0] o);
        expq.push_back('{1'b1, 8'h00, 8'h00});
        dind_coupler_model_i.access(w, p, n, s, o, 8'h5a);
    endtask

    // expected diagnostic byte from the bench's own copy of state
    function automatic logic [7:0] dbyte(int i);
        logic [7:0] wb, pe, r;
        wb = sense_m & wbe_m;
        for (int n = 0; n < 8; n++) begin
            r = filt_m[n / 2] >> (4 * (n % 2));
            pe[n] = (r[3:0] == 4'h0) || (r[3:0] > 4'h7);
        end
        case (i)
            0: r = {|pe, 2'b00, aux_m, |(wb | pe), aux_m,
                ovf_m | comm_m, mf_m};
            1: r = 8'h1f;
            3: r = {3'b000, comm_m, ovf_m, 3'b000};
            4: r = 8'h70;
            5, 6: r = 8'h08;
            7: r = wb | pe;
            default: r = (i >= 8) ? {3'b0, wb[i-8], 3'b0, pe[i-8]} : 8'h0;
        endcase
        return (on_m || i inside {1, 4, 5, 6}) ? r : 8'h00;
    endfunction

    // reads bytes 0..15 over every access path
    task automatic rd_all();
        logic [7:0] b;
        for (int i = 0; i < 16; i++) begin
            b = dbyte(i);
            rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'(i), b, b);
            rd(DIND_PATH_INDEX, 16'h2f01, 8'h00, 5'(i), b, b);
            rd(DIND_PATH_SUBINDEX, 16'h5005, 8'(i + 2), 5'h0, b, b);
            if (i < 4) begin
                rd(DIND_PATH_RECORD, 16'h0000, 8'h00, 5'(i), b, b);
                rd(DIND_PATH_INDEX, 16'h2f00, 8'h00, 5'(i), b, b);
            end
        end
        gap(3);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog, well past the longest filter sweep
    initial begin
        #450us;
        mismatches++;
        end_of_test();
    end

    // main sequence
    initial begin
        {nrst, module_fail, aux_supply_missing, diag_overflow} = '0;
        {comm_error, input_channel, wire_break_sense, lvl} = '0;
        {on_m, mf_m, aux_m, ovf_m, comm_m, wbe_m, sense_m} = '0;
        filt_m = {4{8'h11}};
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_all();
        for (int i = 16; i < 20; i++)
            rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'(i), 8'h00, 8'h00);
        bd(1'b0, DIND_PATH_RECORD, 16'h0002, 8'h00, 5'h0);
        bd(1'b1, DIND_PATH_RECORD, 16'h0001, 8'h00, 5'h0);
        bd(1'b0, DIND_PATH_SUBINDEX, 16'h5005, 8'h12, 5'h0);
        bd(1'b0, DIND_PATH_RECORD, 16'h0000, 8'h00, 5'h4);
        rd(DIND_PATH_INDEX, 16'h3100, 8'h00, 5'h0, 8'h00, 8'h00);
        gap(3);
        chk(8'h00, 8'(n_alarm));
        // enables written before traffic, as the stopped state asks
        wbe_m = 8'(rnd() | 32'h00000001);
        wr(DIND_PATH_RECORD, 16'h0000, 8'h00, 5'h0, 8'h40);
        wr(DIND_PATH_INDEX, 16'h3101, 8'h00, 5'h0, wbe_m);
        rd(DIND_PATH_SUBINDEX, 16'h3100, 8'h02, 5'h0, wbe_m, wbe_m);
        on_m = 1'b1;
        gap(3);
        while (((cyc / US) & 255) != 128) @(posedge ref_clk);
        tk = cyc / US;
        sense_m = 8'(rnd() | 32'h00000001);
        wire_break_sense <= sense_m;
        repeat (10) @(posedge ref_clk);
        chk(8'h01, 8'(n_alarm));
        rd_all();
        rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'd16, 8'h78, 8'h88);
        for (int i = 1; i < 4; i++) begin
            rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'(16 + i),
                tk[8*i+:8], tk[8*i+:8]);
            rd(DIND_PATH_SUBINDEX, 16'h5005, 8'h13, 5'(i),
                tk[8*i+:8], tk[8*i+:8]);
        end
        module_fail <= 1'b1;
        aux_supply_missing <= 1'b1;
        {mf_m, aux_m} = 2'b11;
        gap(4);
        rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'h0, dbyte(0), dbyte(0));
        module_fail <= 1'b0;
        aux_supply_missing <= 1'b0;
        diag_overflow <= 1'b1;
        comm_error <= 1'b1;
        {mf_m, aux_m, ovf_m, comm_m} = 4'b0011;
        gap(4);
        rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'h3, 8'h18, 8'h18);
        rd(DIND_PATH_RECORD, 16'h0001, 8'h00, 5'h0, dbyte(0), dbyte(0));
        diag_overflow <= 1'b0;
        comm_error <= 1'b0;
        {ovf_m, comm_m} = 2'b00;
        wr(DIND_PATH_SUBINDEX, 16'h3100, 8'h01, 5'h0, 8'h00);
        on_m = 1'b0;
        gap(4);
        rd_all();
        wr(DIND_PATH_INDEX, 16'h3100, 8'h00, 5'h0, 8'h40);
        wr(DIND_PATH_INDEX, 16'h3103, 8'h00, 5'h0, 8'h09);
        on_m = 1'b1;
        filt_m[1] = 8'h09;
        gap(4);
        rd_all();
        wr(DIND_PATH_RECORD, 16'h0081, 8'h00, 5'h0, 8'h11);
        rd(DIND_PATH_RECORD, 16'h0081, 8'h00, 5'h0, 8'h11, 8'h11);
        filt_m[1] = 8'h11;
        sense_m = '0;
        wire_break_sense <= '0;
        gap(4);
        // spike shorter than 100 us on channel 0 is dropped
        input_channel <= 8'h01;
        repeat (US * 50) @(posedge ref_clk);
        input_channel <= 8'h00;
        chk_in(8'h00);
        repeat (US * 120) @(posedge ref_clk);
        chk_in(8'h00);
        // every code 1..7 on the odd channel of the first pair
        for (int c = 1; c < 8; c++) begin
            wr(DIND_PATH_RECORD, 16'h0080, 8'h00, 5'h0,
                {4'(c), 4'h1});
            filt_m[0] = {4'(c), 4'h1};
            gap(4);
            lvl = ~lvl;
            input_channel <= {6'b0, lvl, 1'b0};
            repeat (US * (dly[c] - 2)) @(posedge ref_clk);
            chk_in({6'b0, ~lvl, 1'b0});
            repeat (US * 5) @(posedge ref_clk);
            chk_in({6'b0, lvl, 1'b0});
        end
        rd_all();
        gap(4);
        chk(8'h00, 8'(expq.size()));
        end_of_test();
    end
endmodule
